// ==== rtl/urdr_core.sv ====
// receive data recovery with wishbone registers and interrupt
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - line is sampled only on the oversample tick, sixteen per bit
// - phase counter restarts at each start edge
// - phase realigns on a falling edge after a data bit voted 1
// - start edge is a low sample after three high samples
// - start edge begins a 16 tick phase count defining sample points
// - phases 3,5,7 verify start; one high sample sets noise flag
// - two or more high verify samples restart the search, no noise
// - data bit is majority of phases 8,9,10; disagreement sets noise
// - start bit phases 8,9,10 only set noise if high; bit stays 0
// - stop majority zero sets framing error; disagreement sets noise
// - noise before start verification only restarts the search
// - mid-bit noise in the start bit does not reset the phase
// - framing error set when stop bit is not a recovered 1
// - a break character sets framing error like a missing stop
// - framing error and data full flag are set together
// - finished frame moves data to holding register, sets full flag
// - eight or nine data bits by control bit; ninth kept in bit 8 of the holding register
////////////////////////////////////////////////////////////////////////////
module urdr_core
   import urdr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        rx_i,
   input  wire logic        oversample_tick_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o
);

   logic         rx_meta_reg;
   logic         rx_sync_reg;
   logic [2:0]   hist_reg;
   urdr_state_t  state_reg;
   logic [4:0]   phase_reg;
   logic         v3_reg;
   logic         v5_reg;
   logic         m8_reg;
   logic         m9_reg;
   logic [8:0]   shift_reg;
   logic [3:0]   bitcnt_reg;
   logic         armed_reg;
   logic [8:0]   data_reg;
   logic [1:0]   ctrl_reg;
   logic [2:0]   status_reg;
   logic [2:0]   status_next;
   logic [2:0]   mask_reg;
   logic         ack_reg;
   logic [31:0]  dat_o_reg;

   logic         smp;
   logic         tick;
   logic         en;
   logic         in_mid;
   logic [1:0]   vones;
   logic         maj;
   logic         agree;
   logic         start_edge_w;
   logic         start_bad_w;
   logic         start_noisy_w;
   logic         decide_w;
   logic         resync_w;
   logic         frame_done_w;
   logic         noise_set_w;
   logic         fe_set_w;
   logic [3:0]   nbits;
   logic         req;
   logic         wr_en;
   logic [2:0]   stat_clr;
   logic [31:0]  rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // two stage synchroniser on the receive line
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= rx_i;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // decode of sample points and votes
   assign smp    = rx_sync_reg;
   assign tick   = oversample_tick_i;
   assign en     = ctrl_reg[CTRL_EN];
   assign nbits  = ctrl_reg[CTRL_NINE] ? NBITS9 : NBITS8;
   assign in_mid = (phase_reg >= PH_M1) && (phase_reg <= PH_M3);
   assign vones  = {1'b0, v3_reg} + {1'b0, v5_reg} + {1'b0, smp};
   assign maj    = (m8_reg & m9_reg) | (m8_reg & smp) | (m9_reg & smp);
   assign agree  = (m8_reg == m9_reg) && (m9_reg == smp);

   // low after three highs while hunting
   assign start_edge_w = (state_reg == URDR_HUNT) && tick && en &&
                         !smp && (hist_reg == 3'h7);
   // verification at the third sample point
   assign start_bad_w   = (state_reg == URDR_START) && tick &&
                          (phase_reg == PH_V3) && (vones >= 2'h2);
   assign start_noisy_w = (state_reg == URDR_START) && tick &&
                          (phase_reg == PH_V3) && (vones == 2'h1);
   // bit decision at the last mid-bit sample
   assign decide_w = tick && (phase_reg == PH_M3) &&
                     (state_reg != URDR_HUNT);
   assign frame_done_w = decide_w && (state_reg == URDR_STOP);
   // falling edge after a bit that voted 1
   assign resync_w = (state_reg == URDR_DATA) && armed_reg && tick &&
                     hist_reg[0] && !smp && !in_mid;

   // noise and framing events
   assign noise_set_w = start_noisy_w ||
        (decide_w && (state_reg == URDR_START) &&
         (m8_reg || m9_reg || smp)) ||
        (decide_w && (state_reg != URDR_START) && !agree);
   assign fe_set_w = frame_done_w && !maj;

   ////////////////////////////////////////////////////////////////////////
   // history of the last three line samples
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hist_reg <= 3'h0;
      end else if (start_bad_w || frame_done_w || !en) begin
         hist_reg <= 3'h0; // search needs three fresh highs
      end else if (tick) begin
         hist_reg <= {hist_reg[1:0], smp};
      end
   end

   // phase counter 1 to 16 over the bit time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg <= PH_FIRST;
      end else if (start_edge_w || resync_w) begin
         // the edge tick itself is phase 1, so the next tick is phase 2
         phase_reg <= PH_FIRST + 5'h01;
      end else if (start_bad_w || state_reg == URDR_HUNT) begin
         phase_reg <= PH_FIRST;
      end else if (tick) begin
         if (phase_reg == PH_LAST) begin
            phase_reg <= PH_FIRST;
         end else begin
            phase_reg <= phase_reg + 5'h01;
         end
      end
   end

   // capture of verify and mid-bit samples
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         v3_reg <= 1'b0;
         v5_reg <= 1'b0;
         m8_reg <= 1'b0;
         m9_reg <= 1'b0;
      end else if (tick) begin
         if (phase_reg == PH_V1) begin
            v3_reg <= smp;
         end
         if (phase_reg == PH_V2) begin
            v5_reg <= smp;
         end
         if (phase_reg == PH_M1) begin
            m8_reg <= smp;
         end
         if (phase_reg == PH_M2) begin
            m9_reg <= smp;
         end
      end
   end

   // frame sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg  <= URDR_HUNT;
         bitcnt_reg <= 4'h0;
      end else if (!en) begin
         state_reg  <= URDR_HUNT;
         bitcnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            URDR_HUNT: begin
               if (start_edge_w) begin
                  state_reg <= URDR_START;
               end
            end
            URDR_START: begin
               if (start_bad_w) begin
                  state_reg <= URDR_HUNT;
               end else if (decide_w) begin
                  state_reg  <= URDR_DATA; // bit taken as 0
                  bitcnt_reg <= 4'h0;
               end
            end
            URDR_DATA: begin
               if (decide_w) begin
                  bitcnt_reg <= bitcnt_reg + 4'h1;
                  if ((bitcnt_reg + 4'h1) == nbits) begin
                     state_reg <= URDR_STOP;
                  end
               end
            end
            URDR_STOP: begin
               if (decide_w) begin
                  state_reg <= URDR_HUNT;
               end
            end
            default: begin
               state_reg <= URDR_HUNT;
            end
         endcase
      end
   end

   // data shift, lsb first, and edge arming
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_reg <= 9'h000;
         armed_reg <= 1'b0;
      end else if (decide_w && state_reg == URDR_DATA) begin
         shift_reg <= {maj, shift_reg[8:1]};
         armed_reg <= maj;
      end else if (resync_w || state_reg != URDR_DATA) begin
         armed_reg <= 1'b0;
      end
   end

   // holding register loaded at the stop decision
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_reg <= 9'h000;
      end else if (frame_done_w) begin
         if (ctrl_reg[CTRL_NINE]) begin
            data_reg <= shift_reg;
         end else begin
            data_reg <= {1'b0, shift_reg[8:1]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after request, writes at ack edge
   assign req   = wb_cyc_i && wb_stb_i;
   assign wr_en = req && wb_we_i && ack_reg && wb_sel_i[0];
   assign stat_clr = (wr_en && wb_adr_i == ADR_STAT) ? wb_dat_i[2:0] : 3'h0;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         ADR_CTRL: rd_mux = {30'h0, ctrl_reg};
         ADR_STAT: rd_mux = {29'h0, status_reg};
         ADR_MASK: rd_mux = {29'h0, mask_reg};
         ADR_DATA: rd_mux = {23'h0, data_reg};
         default:  rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg   <= 1'b0;
         dat_o_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req && !ack_reg;
         if (req && !ack_reg) begin
            dat_o_reg <= rd_mux;
         end
      end
   end

   // control and mask registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
         mask_reg <= MASK_RST;
      end else if (wr_en) begin
         if (wb_adr_i == ADR_CTRL) begin
            ctrl_reg <= wb_dat_i[1:0];
         end
         if (wb_adr_i == ADR_MASK) begin
            mask_reg <= wb_dat_i[2:0];
         end
      end
   end

   // sticky status, write one to clear, set wins over clear
   always_comb begin
      status_next = status_reg & ~stat_clr;
      status_next[ST_NOISE] = status_next[ST_NOISE] | noise_set_w;
      status_next[ST_FE]    = status_next[ST_FE] | fe_set_w;
      status_next[ST_RECEIVE_DATA_FULL_FLAG]  = status_next[ST_RECEIVE_DATA_FULL_FLAG] | frame_done_w;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= STAT_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   assign wb_dat_o = dat_o_reg;
   assign wb_ack_o = ack_reg;
   assign irq_o    = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_stop_low;
      frame_done_w && !maj;
   endsequence

   sequence s_start_bad;
      (state_reg == URDR_START) && tick && (phase_reg == PH_V3) &&
      (vones >= 2'h2);
   endsequence

   sync_chain_a: assert property (rx_sync_reg == $past(rx_i, 2))
      else $error("receive line not delayed by two flops");

   start_edge_a: assert property (
      (state_reg == URDR_HUNT) && en && tick && !smp &&
      (hist_reg == 3'h7) |=> (state_reg == URDR_START) &&
      (phase_reg == PH_FIRST + 5'h01))
      else $error("start edge not taken");

   hunt_hold_a: assert property (
      (state_reg == URDR_HUNT) && (hist_reg != 3'h7) |=>
      (state_reg == URDR_HUNT))
      else $error("left hunt without three highs");

   start_reject_a: assert property (
      s_start_bad |-> !noise_set_w ##1 (state_reg == URDR_HUNT) &&
      (hist_reg == 3'h0))
      else $error("bad start not rejected quietly");

   start_noise_a: assert property (
      (state_reg == URDR_START) && tick && (phase_reg == PH_V3) &&
      (vones == 2'h1) |=> status_reg[ST_NOISE] &&
      (state_reg == URDR_START))
      else $error("single high verify sample not flagged");

   data_vote_a: assert property (
      decide_w && (state_reg == URDR_DATA) |=>
      shift_reg[8] == (($past(m8_reg) + $past(m9_reg) + $past(smp)) >= 2))
      else $error("data bit is not the majority");

   stop_flags_a: assert property (
      s_stop_low |=> status_reg[ST_FE] && status_reg[ST_RECEIVE_DATA_FULL_FLAG] &&
      (state_reg == URDR_HUNT))
      else $error("framing error not set with data full");

   resync_a: assert property (
      resync_w |=> (phase_reg == PH_FIRST + 5'h01) && !armed_reg)
      else $error("phase not realigned on edge");

   phase_wrap_a: assert property (
      tick && (phase_reg == PH_LAST) && (state_reg != URDR_HUNT) &&
      !resync_w && en |=> (phase_reg == PH_FIRST))
      else $error("phase did not wrap after sixteen");

   bus_ack_a: assert property (
      req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle after request");

endmodule

// ==== shared/urdr_pkg.sv ====
// constants and types for the receive data recovery block
package urdr_pkg;

   // oversample ticks per bit time
   localparam int          URDR_OVERSAMPLE = 16;
   // clock rate of clk_i in hertz
   localparam int          URDR_CLK_HZ     = 50_000_000;

   // phase positions within one bit time, counted 1 to 16
   localparam logic [4:0]  PH_FIRST = 5'h01;
   localparam logic [4:0]  PH_V1    = 5'h03;
   localparam logic [4:0]  PH_V2    = 5'h05;
   localparam logic [4:0]  PH_V3    = 5'h07;
   localparam logic [4:0]  PH_M1    = 5'h08;
   localparam logic [4:0]  PH_M2    = 5'h09;
   localparam logic [4:0]  PH_M3    = 5'h0A;
   localparam logic [4:0]  PH_LAST  = 5'h10;

   // data bits per character
   localparam logic [3:0]  NBITS8   = 4'h8;
   localparam logic [3:0]  NBITS9   = 4'h9;

   // byte addresses of the registers
   localparam logic [7:0]  ADR_CTRL = 8'h00;
   localparam logic [7:0]  ADR_STAT = 8'h04;
   localparam logic [7:0]  ADR_MASK = 8'h08;
   localparam logic [7:0]  ADR_DATA = 8'h0C;

   // control fields
   localparam int          CTRL_EN   = 0;
   localparam int          CTRL_NINE = 1;
   localparam logic [1:0]  CTRL_RST  = 2'h0;

   // status and mask fields
   localparam int          ST_RECEIVE_DATA_FULL_FLAG  = 0;
   localparam int          ST_NOISE = 1;
   localparam int          ST_FE    = 2;
   localparam logic [2:0]  STAT_RST = 3'h0;
   localparam logic [2:0]  MASK_RST = 3'h0;

   // receiver states
   typedef enum logic [3:0] {
      URDR_HUNT  = 4'h1,
      URDR_START = 4'h2,
      URDR_DATA  = 4'h4,
      URDR_STOP  = 4'h8
   } urdr_state_t;

endpackage

// ==== tb/testbench.sv ====
// self-checking bench for the receive data recovery block
`timescale 1ns/1ns
module testbench;
   import urdr_pkg::*;
   logic        clk_i, rst_i, tick, rx, wb_cyc, wb_stb, wb_we, wb_ack, irq;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_rdat, rd;
   logic [1:0]  tcnt;
   int          n_mismatch, total_checks;
   logic [15:0] sp3 [3] = '{16'h0004, 16'h0010, 16'h0040};
   logic [15:0] rej [3] = '{16'hFF94, 16'hFFD0, 16'hFFC4};
   /////////////////////////////////////////////////////////////////////////
   urdr_core DUT (
      .clk_i(clk_i), .rst_i(rst_i), .rx_i(rx), .oversample_tick_i(tick),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq));
   urdr_tx_model u_tx (.clk_i(clk_i), .tick_i(tick), .rx_o(rx));

   // 50 MHz clock
   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end

   // oversample tick every fourth clock
   always @(posedge clk_i) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end

   // verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one classic wishbone cycle, read data left in rd
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'h1 && n < 50);
      check({31'h0, wb_ack}, 32'h1);
      rd = wb_rdat;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
   endtask

   // read one register and compare
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0, 4'hF);
      check(rd, e);
   endtask

   // character, status, then clear all status bits
   task automatic expect_rx(input logic [31:0] d, input logic [31:0] st);
      rd_chk(ADR_DATA, d);
      rd_chk(ADR_STAT, st);
      xfer(1'h1, ADR_STAT, 32'h7, 4'hF);
   endtask

   // one frame; ni flips phase 9 of that data bit, ext stretches ones
   task automatic send(input logic [8:0] d, input logic nine,
                       input logic [15:0] sp, input logic [15:0] stp,
                       input int ni, input int ext);
      logic [15:0] p;
      u_tx.idle(4);
      u_tx.bits(sp);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         p = d[i] ? 16'hFFFF : 16'h0000;
         if (i == ni) p = p ^ 16'h0100;
         u_tx.bits(p);
         if (d[i]) u_tx.idle(ext);
      end
      u_tx.bits(stp);
      u_tx.idle(4);
   endtask

   // watchdog on a hung run
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      complete_run();
   end

   // main sequence
   initial begin
      {tcnt, tick, wb_cyc, wb_stb, wb_we} = '0;
      {wb_adr, wb_sel, wb_dat, rd} = '0;
      n_mismatch = 0;
      total_checks = 0;
      rst_i = 1'h1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int a = 0; a < 20; a += 4) begin
         rd_chk(a[7:0], 32'h0);
      end
      check({31'h0, irq}, 32'h0);
      // receiver still disabled: frame ignored
      send(9'h0A5, 1'h0, 16'h0000, 16'hFFFF, 99, 0);
      rd_chk(ADR_STAT, 32'h0);
      xfer(1'h1, ADR_CTRL, 32'h1, 4'hF);
      xfer(1'h1, ADR_MASK, 32'h1, 4'hF);
      xfer(1'h1, ADR_CTRL, 32'h0, 4'hE);
      rd_chk(ADR_CTRL, 32'h1);
      send(9'h0A5, 1'h0, 16'h0000, 16'hFFFF, 99, 0);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h1);
      xfer(1'h1, ADR_MASK, 32'h6, 4'hF);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0);
      expect_rx(32'hA5, 32'h1);
      xfer(1'h1, ADR_MASK, 32'h7, 4'hF);
      // one high start verification sample
      for (int i = 0; i < 3; i++) begin
         send(9'h03C, 1'h0, sp3[i], 16'hFFFF, 99, 0);
         expect_rx(32'h3C, 32'h3);
      end
      // two high verification samples reject the start quietly
      for (int i = 0; i < 3; i++) begin
         u_tx.bits(rej[i]);
         send(9'h05A, 1'h0, 16'h0000, 16'hFFFF, 99, 0);
         expect_rx(32'h5A, 32'h1);
      end
      send(9'h0C3, 1'h0, 16'h0100, 16'hFFFF, 99, 0);
      expect_rx(32'hC3, 32'h3);
      send(9'h0A5, 1'h0, 16'h0000, 16'hFFFF, 0, 0);
      expect_rx(32'hA5, 32'h3);
      send(9'h0A5, 1'h0, 16'h0000, 16'hFFFF, 3, 0);
      expect_rx(32'hA5, 32'h3);
      send(9'h081, 1'h0, 16'h0000, 16'hFEFF, 99, 0);
      expect_rx(32'h81, 32'h3);
      send(9'h081, 1'h0, 16'h0000, 16'h0000, 99, 0);
      expect_rx(32'h81, 32'h5);
      send(9'h000, 1'h0, 16'h0000, 16'h0000, 99, 0);
      expect_rx(32'h0, 32'h5);
      // slow ones drift four ticks each, realigned at each falling edge
      send(9'h055, 1'h0, 16'h0000, 16'hFFFF, 99, 4);
      expect_rx(32'h55, 32'h1);
      xfer(1'h1, ADR_CTRL, 32'h3, 4'hF);
      send(9'h1A5, 1'h1, 16'h0000, 16'hFFFF, 99, 0);
      expect_rx(32'h1A5, 32'h1);
      xfer(1'h1, ADR_CTRL, 32'h1, 4'hF);
      send(9'h1FF, 1'h0, 16'h0000, 16'hFFFF, 99, 0);
      expect_rx(32'hFF, 32'h1);
      complete_run();
   end
endmodule

// ==== tb/urdr_tx_model.sv ====
// remote serial transmitter model driving the receive line
`timescale 1ns/1ns
module urdr_tx_model (
   input  wire logic clk_i,
   input  wire logic tick_i,
   output logic      rx_o
);
   // line idles high between frames
   initial rx_o = 1'h1;

   // one line value per oversample tick, changed just after the tick edge
   task automatic put(input logic v);
      do @(posedge clk_i); while (tick_i !== 1'h1);
      rx_o <= v;
   endtask

   // sixteen ticks, lowest bit first, bit 0 is phase 1
   task automatic bits(input logic [15:0] p);
      for (int i = 0; i < 16; i++) begin
         put(p[i]);
      end
   endtask

   // high line for n ticks
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) begin
         put(1'h1);
      end
   endtask
endmodule
